// ### mmrp_cfg.svh
`ifndef MMRP_CFG_SVH
`define MMRP_CFG_SVH
`define MMRP_PKT_W 38
`define MMRP_WORD_W 76
`define MMRP_ADDR_W 25
`define MMRP_ADDR_LO_W 12
`define MMRP_SEQ_ADDR_W 13
`define MMRP_BANK_W 4
`define MMRP_CODE_W 4
`define MMRP_DEST_W 7
`define MMRP_RELAY_DEPTH 6
`define MMRP_HOLD_DEPTH 4
`define MMRP_SEQ_IN_DEPTH 4
`define MMRP_SEQ_OUT_DEPTH 9
`define MMRP_HOST_Q_DEPTH 32
`define MMRP_RET_DEPTH 6
`define MMRP_CRED_W 4
`define MMRP_CLK_NS 10
`define MMRP_BANK_CYCLE_NS 40
`define MMRP_BANK_CYC ((`MMRP_BANK_CYCLE_NS + `MMRP_CLK_NS - 1) / `MMRP_CLK_NS)
`define MMRP_MEM_AW 4
`define MMRP_SPARE_POS_W 7
`define MMRP_PORT_ID 2'h0
`endif

// ### mmrp_pkg.sv
`include "mmrp_cfg.svh"
package mmrp_pkg;
  typedef struct packed {
    logic write;
    logic [`MMRP_BANK_W-1:0] bank;
    logic [`MMRP_CODE_W-1:0] code;
    logic [`MMRP_ADDR_W-1:0] addr;
    logic [`MMRP_PKT_W-1:0] lo;
    logic [`MMRP_PKT_W-1:0] hi;
  } mmrp_ref_t;
  typedef struct packed {
    logic write;
    logic [1:0] bank_hi;
    logic [1:0] rp;
    logic [`MMRP_CODE_W-1:0] code;
    logic [`MMRP_SEQ_ADDR_W-1:0] addr;
    logic [`MMRP_WORD_W-1:0] data;
  } mmrp_seq_t;
  typedef struct packed {
    logic [1:0] rp;
    logic [`MMRP_BANK_W-1:0] bank;
    logic [`MMRP_DEST_W-1:0] dest;
    logic [`MMRP_WORD_W-1:0] word;
  } mmrp_ret_t;
  typedef enum logic [1:0] {HS_IDLE = 2'h1, HS_HI = 2'h2} mmrp_host_st_t;
endpackage : mmrp_pkg

// ### mmrp_link_if.sv
`timescale 1ns/10ps
`include "mmrp_cfg.svh"
interface mmrp_link_if;
  logic ref_valid;
  logic ref_write;
  logic [`MMRP_BANK_W-1:0] ref_bank;
  logic [`MMRP_CODE_W-1:0] ref_code;
  logic [`MMRP_ADDR_W-1:0] ref_addr;
  logic [`MMRP_PKT_W-1:0] ref_pkt;
  logic ref_resume;
  logic ret_valid;
  logic [`MMRP_WORD_W-1:0] ret_word;
  logic [`MMRP_DEST_W-1:0] ret_dest;
  logic [`MMRP_BANK_W-1:0] ret_bank;
  logic ret_resume;
  modport host (output ref_valid, ref_write, ref_bank, ref_code, ref_addr, ref_pkt,
                input ref_resume, ret_valid, ret_word, ret_dest, ret_bank, output ret_resume);
  modport dev (input ref_valid, ref_write, ref_bank, ref_code, ref_addr, ref_pkt,
               output ref_resume, ret_valid, ret_word, ret_dest, ret_bank, input ret_resume);
endinterface : mmrp_link_if

// ### mmrp_fifo.sv
`timescale 1ns/10ps
module mmrp_fifo #(
  parameter int W = 8,
  parameter int D = 4,
  parameter int CW = $clog2(D + 1),
  parameter int PW = (D > 1) ? $clog2(D) : 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [CW-1:0] count
);
  logic [W-1:0] mem [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != CW'(D));
  assign out_valid = (count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(D - 1)) ? '0 : PW'(wr_ptr + 1'b1);
      if (pop) rd_ptr <= (rd_ptr == PW'(D - 1)) ? '0 : PW'(rd_ptr + 1'b1);
      count <= CW'(count + push - pop);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule : mmrp_fifo

// ### mmrp_host.sv
`timescale 1ns/10ps
`include "mmrp_cfg.svh"
module mmrp_host (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [`MMRP_BANK_W-1:0] req_bank,
  input wire logic [`MMRP_CODE_W-1:0] req_code,
  input wire logic [`MMRP_ADDR_W-1:0] req_addr,
  input wire logic [`MMRP_WORD_W-1:0] req_data,
  input wire logic [`MMRP_DEST_W-1:0] req_dest,
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [`MMRP_WORD_W-1:0] rsp_word,
  output logic [`MMRP_DEST_W-1:0] rsp_dest,
  output logic [`MMRP_BANK_W-1:0] rsp_bank,
  mmrp_link_if.host link
);
  import mmrp_pkg::*;
  mmrp_ref_t q_in;
  mmrp_ref_t q_head;
  logic q_valid;
  logic q_pop;
  logic [`MMRP_CRED_W-1:0] cred;
  logic [`MMRP_PKT_W-1:0] hi_pkt;
  mmrp_host_st_t st;
  logic ret_pop;

  // reads carry the destination code in the unused write data field
  always_comb begin
    q_in.write = req_write;
    q_in.bank = req_bank;
    q_in.code = req_code;
    q_in.addr = req_addr;
    q_in.lo = req_write ? req_data[`MMRP_PKT_W-1:0]
                        : {{(`MMRP_PKT_W-`MMRP_DEST_W){1'b0}}, req_dest};
    q_in.hi = req_data[`MMRP_WORD_W-1:`MMRP_PKT_W];
  end

  mmrp_fifo #(.W($bits(mmrp_ref_t)), .D(`MMRP_HOST_Q_DEPTH)) u_queue (
    .core_clk(core_clk), .resetn(resetn),
    .in_valid(req_valid), .in_ready(req_ready), .in_data(q_in),
    .out_valid(q_valid), .out_ready(q_pop), .out_data(q_head), .count()
  );

  // no issue while a write's upper packet is still due
  assign q_pop = (st == HS_IDLE) && q_valid && (cred < `MMRP_CRED_W'(`MMRP_RELAY_DEPTH));

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st <= HS_IDLE;
      cred <= '0;
      link.ref_valid <= 1'b0;
      link.ref_write <= 1'b0;
      link.ref_bank <= '0;
      link.ref_code <= '0;
      link.ref_addr <= '0;
      link.ref_pkt <= '0;
      hi_pkt <= '0;
    end else begin
      cred <= `MMRP_CRED_W'(cred + q_pop - link.ref_resume);
      link.ref_valid <= q_pop;
      unique case (st)
        HS_IDLE: begin
          if (q_pop) begin
            link.ref_write <= q_head.write;
            link.ref_bank <= q_head.bank;
            link.ref_code <= q_head.code;
            link.ref_addr <= q_head.addr;
            link.ref_pkt <= q_head.lo;
            hi_pkt <= q_head.hi;
            if (q_head.write) st <= HS_HI;
          end
        end
        HS_HI: begin
          link.ref_pkt <= hi_pkt;
          st <= HS_IDLE;
        end
      endcase
    end
  end

  mmrp_ret_t ret_in;
  mmrp_ret_t ret_head;
  always_comb begin
    ret_in.rp = `MMRP_PORT_ID;
    ret_in.bank = link.ret_bank;
    ret_in.dest = link.ret_dest;
    ret_in.word = link.ret_word;
  end

  mmrp_fifo #(.W($bits(mmrp_ret_t)), .D(`MMRP_RET_DEPTH)) u_ret (
    .core_clk(core_clk), .resetn(resetn),
    .in_valid(link.ret_valid), .in_ready(), .in_data(ret_in),
    .out_valid(rsp_valid), .out_ready(rsp_ready), .out_data(ret_head), .count()
  );
  assign ret_pop = rsp_valid && rsp_ready;
  assign rsp_word = ret_head.word;
  assign rsp_dest = ret_head.dest;
  assign rsp_bank = ret_head.bank;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) link.ret_resume <= 1'b0;
    else link.ret_resume <= ret_pop;
  end
endmodule : mmrp_host

// ### mmrp_device.sv
// Notes on behaviour
// - sender never exceeds receiver buffers, counts outstanding
// - count up per valid, resume counts down
// - processor sends valid, control, then address/data
// - write data: two 38-bit packets, consecutive periods
// - read returns whole 76-bit word at once
// - read destination code rides write field, echoed
// - two relay slices: lower and upper halves
// - relay slices queue six references in order
// - rotating priority, last winner goes lowest
// - four input holding buffers in the mux
// - bank bits 0-1 pick group, rest forwarded
// - writes routed 4x4, lower packet first
// - reads routed back with bank, return path
// - four banks, pairs run 180 degrees apart
// - maintenance-set spare bit replaces bad bit
// - asynchronous mode uses two banks only
// - sequencer takes 13 address bits, code, steering
// - 4-rank input queue feeds per-bank holding
// - other banks proceed, same bank waits
// - readout per bank plus spare bits
// - 9-rank readout queue with aligned tags
// - address split 0-11 even, 12-24 odd
// - write flag means two packets, else one
`timescale 1ns/10ps
`include "mmrp_cfg.svh"
module mmrp_device (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic async_mode,
  input wire logic maint_spare_we,
  input wire logic [1:0] maint_spare_grp,
  input wire logic maint_spare_en,
  input wire logic [`MMRP_SPARE_POS_W-1:0] maint_spare_bit,
  mmrp_link_if.dev link
);
  import mmrp_pkg::*;
  localparam int SW = 1 + 2 + 2 + `MMRP_SEQ_ADDR_W + `MMRP_PKT_W;

  mmrp_ref_t cap;
  logic cap_pend;
  logic push_q;
  logic phase;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cap <= '0;
      cap_pend <= 1'b0;
      push_q <= 1'b0;
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
      cap_pend <= link.ref_valid && link.ref_write;
      push_q <= (link.ref_valid && !link.ref_write) || cap_pend;
      if (link.ref_valid) begin
        cap.write <= link.ref_write;
        cap.bank <= link.ref_bank;
        cap.code <= link.ref_code;
        cap.addr <= link.ref_addr;
        cap.lo <= link.ref_pkt;
        cap.hi <= '0;
      end else if (cap_pend) begin
        cap.hi <= link.ref_pkt;
      end
    end
  end

  // relay slices: even carries lower half, odd the upper half
  logic [1:0] sl_v;
  logic [SW-1:0] sl_out [2];
  logic relay_pop;
  logic [`MMRP_CRED_W-1:0] hold_cnt;
  logic hold_pop;

  for (genvar s = 0; s < 2; s++) begin : g_slice
    logic [SW-1:0] sl_in;
    assign sl_in = (s == 0)
      ? {cap.write, cap.bank[1:0], cap.code[1:0], 1'b0, cap.addr[11:0], cap.lo}
      : {cap.write, cap.bank[3:2], cap.code[3:2], cap.addr[24:12], cap.hi};
    mmrp_fifo #(.W(SW), .D(`MMRP_RELAY_DEPTH)) u_relay (
      .core_clk(core_clk), .resetn(resetn),
      .in_valid(push_q), .in_ready(), .in_data(sl_in),
      .out_valid(sl_v[s]), .out_ready(relay_pop), .out_data(sl_out[s]), .count()
    );
  end

  assign relay_pop = (&sl_v) && (hold_cnt < `MMRP_CRED_W'(`MMRP_HOLD_DEPTH));

  mmrp_ref_t hold_in;
  mmrp_ref_t hold_head;
  logic hold_push;
  logic hold_v;
  logic [`MMRP_CRED_W-1:0] sq_cnt [4];
  logic [3:0] sq_push;
  mmrp_seq_t sq_data;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      link.ref_resume <= 1'b0;
      hold_cnt <= '0;
      hold_push <= 1'b0;
      hold_in <= '0;
      sq_push <= '0;
      sq_data <= '0;
    end else begin
      link.ref_resume <= relay_pop;
      hold_cnt <= `MMRP_CRED_W'(hold_cnt + relay_pop - hold_pop);
      hold_push <= relay_pop;
      hold_in <= {sl_out[0][SW-1], sl_out[1][SW-2 -: 2], sl_out[0][SW-2 -: 2],
                  sl_out[1][SW-4 -: 2], sl_out[0][SW-4 -: 2],
                  sl_out[1][`MMRP_PKT_W +: `MMRP_SEQ_ADDR_W],
                  sl_out[0][`MMRP_PKT_W +: `MMRP_ADDR_LO_W],
                  sl_out[0][`MMRP_PKT_W-1:0], sl_out[1][`MMRP_PKT_W-1:0]};
      sq_push <= hold_pop ? (4'h1 << hold_head.bank[1:0]) : 4'h0;
      sq_data.write <= hold_head.write;
      sq_data.bank_hi <= hold_head.bank[3:2];
      sq_data.rp <= `MMRP_PORT_ID;
      sq_data.code <= hold_head.code;
      sq_data.addr <= hold_head.addr[`MMRP_SEQ_ADDR_W-1:0];
      sq_data.data <= {hold_head.hi, hold_head.lo};
    end
  end

  mmrp_fifo #(.W($bits(mmrp_ref_t)), .D(`MMRP_HOLD_DEPTH)) u_hold (
    .core_clk(core_clk), .resetn(resetn),
    .in_valid(hold_push), .in_ready(), .in_data(hold_in),
    .out_valid(hold_v), .out_ready(hold_pop), .out_data(hold_head), .count()
  );
  assign hold_pop = hold_v
    && (sq_cnt[hold_head.bank[1:0]] < `MMRP_CRED_W'(`MMRP_SEQ_IN_DEPTH));

  logic [3:0] ov;
  mmrp_ret_t od [4];
  logic [3:0] opop;

  for (genvar g = 0; g < 4; g++) begin : g_seq
    mmrp_seq_t in_head;
    mmrp_seq_t hreg [4];
    logic in_v;
    logic in_pop;
    logic [1:0] hb;
    logic [3:0] hv;
    logic [2:0] busy [4];
    logic st_any;
    logic [1:0] st_b;
    logic [3:0] out_cnt;
    logic room;
    logic [`MMRP_WORD_W:0] mem [0:63];
    logic sp_en;
    logic [`MMRP_SPARE_POS_W-1:0] sp_pos;
    logic rd_v;
    logic [`MMRP_WORD_W:0] rd_raw;
    mmrp_ret_t rd_info;
    mmrp_ret_t rd_out;
    logic [`MMRP_CRED_W-1:0] sc;

    mmrp_fifo #(.W($bits(mmrp_seq_t)), .D(`MMRP_SEQ_IN_DEPTH)) u_in (
      .core_clk(core_clk), .resetn(resetn),
      .in_valid(sq_push[g]), .in_ready(), .in_data(sq_data),
      .out_valid(in_v), .out_ready(in_pop), .out_data(in_head), .count()
    );
    assign hb = async_mode ? {1'b0, in_head.bank_hi[0]} : in_head.bank_hi;
    assign in_pop = in_v && !hv[hb];
    // a push still in flight counts too, or the input queue overruns by one
    assign sq_cnt[g] = `MMRP_CRED_W'(sc + sq_push[g]);
    assign room = (4'(out_cnt + rd_v) < 4'(`MMRP_SEQ_OUT_DEPTH));

    // one bank start per cycle; the phase bit gives each pair 180 degree slots
    always_comb begin
      st_any = 1'b0;
      st_b = 2'h0;
      for (int b = 3; b >= 0; b--) begin
        if (hv[b] && busy[b] == 3'h0 && phase == b[0] && (!async_mode || b < 2)
            && (hreg[b].write || room)) begin
          st_any = 1'b1;
          st_b = 2'(b);
        end
      end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
        sc <= '0;
        hv <= '0;
        rd_v <= 1'b0;
        sp_en <= 1'b0;
        sp_pos <= '0;
        for (int b = 0; b < 4; b++) busy[b] <= 3'h0;
      end else begin
        sc <= `MMRP_CRED_W'(sc + sq_push[g] - in_pop);
        if (in_pop) hv[hb] <= 1'b1;
        if (st_any) hv[st_b] <= 1'b0;
        for (int b = 0; b < 4; b++) begin
          if (st_any && st_b == 2'(b)) busy[b] <= 3'(`MMRP_BANK_CYC - 1);
          else if (busy[b] != 3'h0) busy[b] <= busy[b] - 3'h1;
        end
        rd_v <= st_any && !hreg[st_b].write;
        if (maint_spare_we && maint_spare_grp == 2'(g)) begin
          sp_en <= maint_spare_en;
          sp_pos <= maint_spare_bit;
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (in_pop) hreg[hb] <= in_head;
      if (st_any && hreg[st_b].write)
        mem[{st_b, hreg[st_b].addr[`MMRP_MEM_AW-1:0]}] <=
          {hreg[st_b].data[sp_pos], hreg[st_b].data};
      rd_raw <= mem[{st_b, hreg[st_b].addr[`MMRP_MEM_AW-1:0]}];
      rd_info.rp <= hreg[st_b].rp;
      rd_info.bank <= {hreg[st_b].bank_hi, 2'(g)};
      rd_info.dest <= hreg[st_b].data[`MMRP_DEST_W-1:0];
      rd_info.word <= '0;
    end

    always_comb begin
      rd_out = rd_info;
      rd_out.word = rd_raw[`MMRP_WORD_W-1:0];
      if (sp_en) rd_out.word[sp_pos] = rd_raw[`MMRP_WORD_W];
    end

    mmrp_fifo #(.W($bits(mmrp_ret_t)), .D(`MMRP_SEQ_OUT_DEPTH)) u_out (
      .core_clk(core_clk), .resetn(resetn),
      .in_valid(rd_v), .in_ready(), .in_data(rd_out),
      .out_valid(ov[g]), .out_ready(opop[g]), .out_data(od[g]), .count(out_cnt)
    );
  end

  logic [1:0] last_g;
  logic gnt_any;
  logic [1:0] gnt;
  logic [`MMRP_CRED_W-1:0] ret_cnt;

  always_comb begin
    gnt_any = 1'b0;
    gnt = 2'h0;
    for (int k = 3; k >= 0; k--) begin
      if (ov[2'(last_g + 1 + k)] && od[2'(last_g + 1 + k)].rp == `MMRP_PORT_ID
          && ret_cnt < `MMRP_CRED_W'(`MMRP_RET_DEPTH)) begin
        gnt_any = 1'b1;
        gnt = 2'(last_g + 1 + k);
      end
    end
  end
  assign opop = gnt_any ? (4'h1 << gnt) : 4'h0;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      last_g <= 2'h3;
      ret_cnt <= '0;
      link.ret_valid <= 1'b0;
      link.ret_word <= '0;
      link.ret_dest <= '0;
      link.ret_bank <= '0;
    end else begin
      ret_cnt <= `MMRP_CRED_W'(ret_cnt + gnt_any - link.ret_resume);
      link.ret_valid <= gnt_any;
      if (gnt_any) begin
        last_g <= gnt;
        link.ret_word <= od[gnt].word;
        link.ret_dest <= od[gnt].dest;
        link.ret_bank <= od[gnt].bank;
      end
    end
  end
endmodule : mmrp_device

// ### mmrp_link_sva.sv
`timescale 1ns/10ps
`include "mmrp_cfg.svh"
module mmrp_link_sva (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic ref_valid,
  input wire logic ref_write,
  input wire logic [`MMRP_BANK_W-1:0] ref_bank,
  input wire logic [`MMRP_CODE_W-1:0] ref_code,
  input wire logic [`MMRP_ADDR_W-1:0] ref_addr,
  input wire logic [`MMRP_PKT_W-1:0] ref_pkt,
  input wire logic ref_resume,
  input wire logic ret_valid,
  input wire logic [`MMRP_WORD_W-1:0] ret_word,
  input wire logic [`MMRP_DEST_W-1:0] ret_dest,
  input wire logic [`MMRP_BANK_W-1:0] ret_bank,
  input wire logic ret_resume
);
  logic [3:0] fwd_cnt;
  logic [3:0] ret_cnt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  // outstanding references per direction, as the sender's credit sees them
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      fwd_cnt <= 4'h0;
    end else begin
      fwd_cnt <= fwd_cnt + 4'(ref_valid) - 4'(ref_resume);
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ret_cnt <= 4'h0;
    end else begin
      ret_cnt <= ret_cnt + 4'(ret_valid) - 4'(ret_resume);
    end
  end

  a_fwd_no_overrun: assert property (ref_valid |-> fwd_cnt < 4'h6)
    else $error("forward reference sent with all relay buffers owed");
  a_ret_no_overrun: assert property (ret_valid |-> ret_cnt < 4'h6)
    else $error("return sent with all host buffers owed");
  a_resume_owed: assert property (ref_resume |-> fwd_cnt != 4'h0)
    else $error("forward resume with nothing outstanding");
  a_ret_resume_owed: assert property (ret_resume |-> ret_cnt != 4'h0)
    else $error("return resume with nothing outstanding");
  a_write_two_pkt: assert property (ref_valid && ref_write |=> !ref_valid)
    else $error("new reference during upper write packet");
  a_ctrl_hold_hi: assert property (ref_valid && ref_write |=> $stable(ref_write)
      && $stable(ref_bank) && $stable(ref_code) && $stable(ref_addr))
    else $error("control changed during upper write packet");
  a_read_dest_field: assert property (ref_valid && !ref_write |-> ref_pkt[37:7] == 31'h0)
    else $error("read packet carries more than the destination code");
  a_ret_fields_hold: assert property (!ret_valid |->
      $stable(ret_word) && $stable(ret_dest) && $stable(ret_bank))
    else $error("return fields changed without a return strobe");
  a_reset_quiet: assert property ($rose(resetn) |->
      !ref_valid && !ref_resume && !ret_valid && !ret_resume)
    else $error("link strobe active at first edge after reset");

  c_write: cover property (ref_valid && ref_write);
  c_read: cover property (ref_valid && !ref_write);
  c_fwd_full: cover property (fwd_cnt == 4'h6);
  c_ret_full: cover property (ret_cnt == 4'h6);
endmodule : mmrp_link_sva

// ### tb.sv
`timescale 1ns/10ps
`include "mmrp_cfg.svh"
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [3:0] req_bank = 4'h0;
  logic [3:0] req_code = 4'h0;
  logic [24:0] req_addr = 25'h0;
  logic [75:0] req_data = 76'h0;
  logic [6:0] req_dest = 7'h0;
  logic rsp_ready = 1'b0;
  logic async_mode = 1'b0;
  logic maint_spare_we = 1'b0;
  logic [1:0] maint_spare_grp = 2'h0;
  logic maint_spare_en = 1'b0;
  logic [6:0] maint_spare_bit = 7'h0;
  logic req_ready;
  logic rsp_valid;
  logic [75:0] rsp_word;
  logic [6:0] rsp_dest;
  logic [3:0] rsp_bank;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rsp_mode = 0;
  int n_pend = 0;
  logic [75:0] mem [256];
  logic [75:0] exp_word [128];
  logic [3:0] exp_bank [128];
  bit pend [128];
  logic [6:0] next_dest = 7'h0;
  logic saw_full = 1'b0;

  mmrp_link_if link ();
  mmrp_host u_mmrp_host (.core_clk, .resetn, .req_valid, .req_ready, .req_write, .req_bank,
    .req_code, .req_addr, .req_data, .req_dest, .rsp_valid, .rsp_ready, .rsp_word, .rsp_dest,
    .rsp_bank, .link(link));
  mmrp_device u_mmrp_device (.core_clk, .resetn, .async_mode, .maint_spare_we,
    .maint_spare_grp, .maint_spare_en, .maint_spare_bit, .link(link));
  mmrp_link_sva u_mmrp_link_sva (.core_clk, .resetn, .ref_valid(link.ref_valid),
    .ref_write(link.ref_write), .ref_bank(link.ref_bank), .ref_code(link.ref_code),
    .ref_addr(link.ref_addr), .ref_pkt(link.ref_pkt), .ref_resume(link.ref_resume),
    .ret_valid(link.ret_valid), .ret_word(link.ret_word), .ret_dest(link.ret_dest),
    .ret_bank(link.ret_bank), .ret_resume(link.ret_resume));

  always #5 core_clk = ~core_clk;

  // async parts have one bank per pair, so bank bit 3 aliases there
  function automatic logic [7:0] mem_key(input logic [3:0] b, input logic [24:0] a);
    return {b[3] & ~async_mode, b[2:0], a[3:0]};
  endfunction : mem_key

  function automatic logic [75:0] rand_word();
    return {12'($urandom), $urandom, $urandom};
  endfunction : rand_word

  task automatic give_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk_word(input logic [75:0] got, input logic [75:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_small(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_small

  // valid stays up between calls so requests can go back to back
  task automatic issue(input logic w, input logic [3:0] b, input logic [24:0] a,
                       input logic [75:0] d);
    int n;
    req_valid <= 1'b1;
    req_write <= w;
    req_bank <= b;
    req_addr <= a;
    req_data <= d;
    req_dest <= next_dest;
    req_code <= w ? 4'h2 : 4'h1;
    n = 0;
    @(posedge core_clk);
    while (req_ready !== 1'b1 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) error_cnt++;
    if (w) begin
      mem[mem_key(b, a)] = d;
    end else begin
      exp_word[next_dest] = mem[mem_key(b, a)];
      exp_bank[next_dest] = b;
      pend[next_dest] = 1'b1;
      n_pend++;
      next_dest = next_dest + 7'h1;
    end
  endtask : issue

  task automatic drain();
    int n;
    rsp_mode = 2;
    n = 0;
    while (n_pend != 0 && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) error_cnt++;
  endtask : drain

  always @(posedge core_clk) begin
    case (rsp_mode)
      0: rsp_ready <= 1'b0;
      1: rsp_ready <= ($urandom % 4) != 0;
      default: rsp_ready <= 1'b1;
    endcase
    if (req_valid === 1'b1 && req_ready === 1'b0) saw_full <= 1'b1;
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      give_verdict();
    end
  end

  always @(posedge core_clk) begin
    if (resetn && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      chk_small(8'(pend[rsp_dest]), 8'h01);
      chk_word(rsp_word, exp_word[rsp_dest]);
      chk_small(8'(rsp_bank), 8'(exp_bank[rsp_dest]));
      pend[rsp_dest] = 1'b0;
      n_pend--;
    end
  end

  initial begin
    int i;
    logic [3:0] b;
    logic [24:0] a;
    void'($urandom(32'hC5D2033E));
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    // spare set before any data lands, so every stored spare copy is current
    maint_spare_grp <= 2'h1;
    maint_spare_bit <= 7'h4B;
    maint_spare_en <= 1'b1;
    maint_spare_we <= 1'b1;
    @(posedge core_clk);
    maint_spare_we <= 1'b0;
    rsp_mode = 2;
    for (i = 0; i < 256; i++) issue(1'b1, i[7:4], {21'h0, i[3:0]}, rand_word());
    issue(1'b1, 4'hF, 25'h1FFFFFF, {76{1'b1}});
    issue(1'b0, 4'hF, 25'h1FFFFFF, 76'h0);
    rsp_mode = 1;
    for (i = 0; i < 300; i++) begin
      b = 4'($urandom);
      a = 25'($urandom);
      issue(1'($urandom), b, a, rand_word());
      if (i % 8 == 0) issue(1'b0, b, a, 76'h0);
    end
    req_valid <= 1'b0;
    drain();
    chk_small(8'(n_pend), 8'h00);
    // one bank group only, so its buffers fill before the user queue drains
    rsp_mode = 0;
    fork
      begin
        repeat (300) @(posedge core_clk);
        rsp_mode = 2;
      end
    join_none
    for (i = 0; i < 100; i++) issue(1'b0, {2'($urandom), 2'h0}, 25'($urandom), 76'h0);
    req_valid <= 1'b0;
    drain();
    chk_small(8'(saw_full), 8'h01);
    chk_small(8'(n_pend), 8'h00);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    chk_small({6'h0, rsp_valid, req_ready}, 8'h01);
    async_mode <= 1'b1;
    @(posedge core_clk);
    for (i = 0; i < 16; i++) begin
      b = 4'($urandom);
      a = 25'($urandom);
      issue(1'b1, b, a, rand_word());
      issue(1'b0, b ^ 4'h8, a, 76'h0);
    end
    req_valid <= 1'b0;
    drain();
    chk_small(8'(n_pend), 8'h00);
    give_verdict();
  end
endmodule : tb
